//--- include/margin_cmd_pkg.sv
// Constants for the margin-read command sequencer.
// Assumes a 32-bit register port with byte-wide parameter registers.
package margin_cmd_pkg;
    // Register offsets (byte addresses).
    localparam logic [7:0] STATUS_OFS     = 8'h00;
    localparam logic [7:0] MODE_OFS       = 8'h04;
    localparam logic [7:0] PARAM_BASE_OFS = 8'h10;
    localparam int         PARAM_COUNT    = 12;
    // Status register bit positions.
    localparam int ST_VERIFY_BIT   = 0;
    localparam int ST_PROT_BIT     = 4;
    localparam int ST_ACCESS_BIT   = 5;
    localparam int ST_COLLIDE_BIT  = 6;
    localparam int ST_COMPLETE_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    // Mode register bit: command not permitted in mode or security.
    localparam int MODE_DENY_BIT = 0;
    // Command codes.
    localparam logic [7:0] CMD_READ_ONES = 8'h01;
    localparam logic [7:0] CMD_PGM_CHECK = 8'h02;
    // Margin choices.
    localparam logic [7:0] MARGIN_NORMAL  = 8'h00;
    localparam logic [7:0] MARGIN_USER    = 8'h01;
    localparam logic [7:0] MARGIN_FACTORY = 8'h02;
    // Array reference level encoding.
    localparam logic [2:0] LVL_STANDARD  = 3'h0;
    localparam logic [2:0] LVL_NORMAL_1  = 3'h1;
    localparam logic [2:0] LVL_USER_1    = 3'h2;
    localparam logic [2:0] LVL_FACTORY_1 = 3'h3;
    localparam logic [2:0] LVL_USER_0    = 3'h4;
    localparam logic [2:0] LVL_FACTORY_0 = 3'h5;
    // Array geometry.
    localparam int ADDR_W      = 24;
    localparam int BLOCK_BITS  = 17;
    localparam int READ_LAT    = 2;
    localparam int READ_LAT_CW = 2;
endpackage

//--- rtl/margin_read_sequencer.sv
// Margin-read command sequencer: read-ones section and program check.
// Assumes a flash array answering reads after a fixed latency of cycles,
// and a register master that never issues read and write strobes together.
//
// Summary of operation
// - Margin levels only during margin commands.
// - Unknown command code aborts with access error.
// - Invalid parameter byte aborts with access error.
// - Processor read during command sets collision flag.
// - Read-ones: code, address bytes 1 to 3.
// - Read-ones: count bytes 4-5, margin byte 6.
// - Address must be longword aligned.
// - Read-ones reads section, mismatch sets verify failure.
// - Read-ones margin: normal, user, factory.
// - Read-ones: bad margin, address, mode give error.
// - Read-ones: crossing block boundary gives error.
// - Read-ones: zero count gives error.
// - Program check: code, address, margin, expected bytes.
// - Program check reads margin-1 then margin-0.
// - Expected byte 3 sits at start address.
// - Program check margin: user or factory.
// - Program check: bad mode or address gives error.
// - Writing one to complete flag launches command.
// - Failed checks skip execution and set complete.
// - Program check: bad margin error, mismatch verify failure.
`timescale 1ns/1ps
module margin_read_sequencer #(
    parameter int READ_LAT = margin_cmd_pkg::READ_LAT
) (
    input  wire logic        core_clk_i,    // System clock, 250 MHz.
    input  wire logic        rst_n_i,       // Synchronous reset, active low.
    input  wire logic [7:0]  reg_addr_i,    // Register byte address.
    input  wire logic [31:0] reg_wdata_i,   // Register write data.
    input  wire logic        reg_wr_i,      // Write strobe.
    input  wire logic        reg_rd_i,      // Read strobe.
    output logic      [31:0] reg_rdata_o,   // Read data, cycle after strobe.
    input  wire logic        cpu_rd_i,      // Processor reads the array.
    output logic             arr_rd_o,      // Array read request pulse.
    output logic      [23:0] arr_addr_o,    // Array longword address.
    output logic      [2:0]  arr_level_o,   // Array reference level.
    input  wire logic [31:0] arr_rdata_i,   // Array read data.
    output logic             busy_o         // Command running.
);
    localparam int AW = margin_cmd_pkg::ADDR_W;
    localparam int BB = margin_cmd_pkg::BLOCK_BITS;
    localparam int LW = margin_cmd_pkg::READ_LAT_CW;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CHECK = 3'b001,
        S_ISSUE = 3'b010,
        S_WAIT  = 3'b011,
        S_DONE  = 3'b100
    } state_e;

    state_e            state;
    logic [7:0]        param [margin_cmd_pkg::PARAM_COUNT];
    logic              verify_flag;
    logic              prot_flag;
    logic              access_flag;
    logic              collide_flag;
    logic              complete_flag;
    logic              mode_deny;
    logic [AW-1:0]     cur_addr;
    logic [15:0]       remain;
    logic              second_pass;
    logic [LW-1:0]     lat_cnt;

    // Decode of the loaded parameter bytes.
    wire [7:0]    cmd_code   = param[0];
    wire [AW-1:0] start_addr = {param[1], param[2], param[3]};
    wire [15:0]   lw_count   = {param[4], param[5]};
    wire [7:0]    sec_margin = param[6];
    wire [7:0]    chk_margin = param[4];
    // Expected byte 3 is the lowest address, so it is the top byte.
    wire [31:0]   expect_word = {param[11], param[10], param[9], param[8]};
    wire          is_sec = (cmd_code == margin_cmd_pkg::CMD_READ_ONES);
    wire          is_chk = (cmd_code == margin_cmd_pkg::CMD_PGM_CHECK);

    wire [AW+1:0] last_addr = {2'b00, start_addr}
                            + {8'h00, lw_count, 2'b00} - 26'h4;
    wire unaligned  = (start_addr[1:0] != 2'b00);
    wire crosses    = (last_addr[AW+1:BB] != {2'b00, start_addr[AW-1:BB]});
    wire sec_mg_bad = (sec_margin > margin_cmd_pkg::MARGIN_FACTORY);
    wire chk_mg_bad = (chk_margin != margin_cmd_pkg::MARGIN_USER) &&
                      (chk_margin != margin_cmd_pkg::MARGIN_FACTORY);
    wire sec_bad    = unaligned || sec_mg_bad || crosses ||
                      (lw_count == 16'h0000) || mode_deny;
    wire chk_bad    = unaligned || chk_mg_bad || mode_deny;
    wire param_bad  = (is_sec && sec_bad) || (is_chk && chk_bad) ||
                      !(is_sec || is_chk);

    function automatic logic [2:0] level_of(input logic [7:0] mg,
                                            input logic       sec,
                                            input logic       zero);
        logic [2:0] lvl;
        lvl = margin_cmd_pkg::LVL_NORMAL_1;
        if (mg == margin_cmd_pkg::MARGIN_USER) begin
            lvl = zero ? margin_cmd_pkg::LVL_USER_0
                       : margin_cmd_pkg::LVL_USER_1;
        end else if (mg == margin_cmd_pkg::MARGIN_FACTORY) begin
            lvl = zero ? margin_cmd_pkg::LVL_FACTORY_0
                       : margin_cmd_pkg::LVL_FACTORY_1;
        end else if (!sec) begin
            lvl = margin_cmd_pkg::LVL_STANDARD;
        end
        return lvl;
    endfunction

    wire [2:0] run_level = is_sec ? level_of(sec_margin, 1'b1, 1'b0)
                                  : level_of(chk_margin, 1'b0, second_pass);
    wire read_mismatch = is_sec ? (arr_rdata_i != 32'hffff_ffff)
                                : (arr_rdata_i != expect_word);
    wire read_done  = (state == S_WAIT) && (lat_cnt == LW'(READ_LAT - 1));
    wire last_read  = is_sec ? (remain == 16'h0001) : second_pass;

    wire st_wr  = reg_wr_i && (reg_addr_i == margin_cmd_pkg::STATUS_OFS);
    wire clr_access  = st_wr && reg_wdata_i[margin_cmd_pkg::ST_ACCESS_BIT];
    wire clr_prot    = st_wr && reg_wdata_i[margin_cmd_pkg::ST_PROT_BIT];
    wire clr_collide = st_wr && reg_wdata_i[margin_cmd_pkg::ST_COLLIDE_BIT];
    // Launch is blocked while either error flag is still set.
    wire launch = st_wr && reg_wdata_i[margin_cmd_pkg::ST_COMPLETE_BIT] &&
                  complete_flag && !access_flag && !prot_flag;
    wire prm_idx_ok = (reg_addr_i >= margin_cmd_pkg::PARAM_BASE_OFS) &&
                      (reg_addr_i < margin_cmd_pkg::PARAM_BASE_OFS +
                                    8'(4 * margin_cmd_pkg::PARAM_COUNT)) &&
                      (reg_addr_i[1:0] == 2'b00);
    wire [7:0] prm_off = reg_addr_i - margin_cmd_pkg::PARAM_BASE_OFS;
    wire [3:0] prm_idx = prm_off[5:2];
    // Parameter writes are ignored while a command runs.
    wire prm_wr = reg_wr_i && prm_idx_ok && complete_flag;

    wire [7:0] status_word = {complete_flag, collide_flag, access_flag,
                              prot_flag, 3'b000, verify_flag};
    wire [31:0] rd_mux =
        (reg_addr_i == margin_cmd_pkg::STATUS_OFS) ? {24'h0, status_word} :
        (reg_addr_i == margin_cmd_pkg::MODE_OFS)   ? {31'h0, mode_deny}   :
        prm_idx_ok ? {24'h0, param[prm_idx]} : 32'h0000_0000;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < margin_cmd_pkg::PARAM_COUNT; i++) begin
                param[i] <= 8'h00;
            end
            mode_deny <= 1'b0;
        end else if (reg_wr_i) begin
            if (prm_wr) begin
                param[prm_idx] <= reg_wdata_i[7:0];
            end
            if (reg_addr_i == margin_cmd_pkg::MODE_OFS) begin
                mode_deny <= reg_wdata_i[margin_cmd_pkg::MODE_DENY_BIT];
            end
        end
    end

    // Collision: a set in the same cycle as its clear wins.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            collide_flag <= 1'b0;
        end else if (cpu_rd_i && !complete_flag) begin
            collide_flag <= 1'b1;
        end else if (clr_collide) begin
            collide_flag <= 1'b0;
        end
    end

    // No margin command checks protection, so this flag only ever clears.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            prot_flag <= 1'b0;
        end else if (clr_prot) begin
            prot_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state         <= S_IDLE;
            complete_flag <= 1'b1;
            access_flag   <= 1'b0;
            verify_flag   <= 1'b0;
            cur_addr      <= '0;
            remain        <= 16'h0000;
            second_pass   <= 1'b0;
            lat_cnt       <= '0;
        end else begin
            if (clr_access) begin
                access_flag <= 1'b0;
            end
            case (state)
                S_IDLE: begin
                    if (launch) begin
                        complete_flag <= 1'b0;
                        verify_flag   <= 1'b0;
                        state         <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    cur_addr    <= start_addr;
                    remain      <= lw_count;
                    second_pass <= 1'b0;
                    if (param_bad) begin
                        access_flag <= 1'b1;
                        state       <= S_DONE;
                    end else begin
                        state <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    lat_cnt <= '0;
                    state   <= S_WAIT;
                end
                S_WAIT: begin
                    lat_cnt <= lat_cnt + LW'(1);
                    if (read_done) begin
                        if (read_mismatch) begin
                            verify_flag <= 1'b1;
                        end
                        if (last_read) begin
                            state <= S_DONE;
                        end else begin
                            state       <= S_ISSUE;
                            second_pass <= is_chk;
                            remain      <= remain - 16'h0001;
                            if (is_sec) begin
                                cur_addr <= cur_addr + AW'(4);
                            end
                        end
                    end
                end
                S_DONE: begin
                    complete_flag <= 1'b1;
                    state         <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Margins are driven only while a read of a command is in flight.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            arr_rd_o    <= 1'b0;
            arr_addr_o  <= '0;
            arr_level_o <= margin_cmd_pkg::LVL_STANDARD;
            busy_o      <= 1'b0;
        end else begin
            arr_rd_o   <= (state == S_ISSUE);
            arr_addr_o <= cur_addr;
            busy_o     <= (state != S_IDLE);
            if (state == S_ISSUE || state == S_WAIT) begin
                arr_level_o <= run_level;
            end else begin
                arr_level_o <= margin_cmd_pkg::LVL_STANDARD;
            end
        end
    end

    property p_idle_standard;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state == S_IDLE) |=> (arr_level_o == margin_cmd_pkg::LVL_STANDARD);
    endproperty
    a_idle_standard: assert property (p_idle_standard)
        else $error("margin level applied outside a command");

    property p_bad_code;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state == S_CHECK && !is_sec && !is_chk)
            |=> access_flag ##1 complete_flag;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("unknown code did not raise access error");

    property p_zero_count;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state == S_CHECK && is_sec && lw_count == 16'h0000)
            |=> access_flag && !arr_rd_o;
    endproperty
    a_zero_count: assert property (p_zero_count)
        else $error("zero count not rejected");

    property p_unaligned;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state == S_CHECK && unaligned) |=> (state == S_DONE) && access_flag;
    endproperty
    a_unaligned: assert property (p_unaligned)
        else $error("unaligned address not rejected");

    property p_collide;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cpu_rd_i && !complete_flag) |=> collide_flag;
    endproperty
    a_collide: assert property (p_collide)
        else $error("collision flag not set");

    property p_blocked_launch;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (st_wr && reg_wdata_i[margin_cmd_pkg::ST_COMPLETE_BIT] &&
         complete_flag && (access_flag || prot_flag))
            |=> complete_flag && (state == S_IDLE);
    endproperty
    a_blocked_launch: assert property (p_blocked_launch)
        else $error("launch accepted with error flag set");

    property p_chk_bad_margin;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state == S_CHECK && is_chk && chk_margin == 8'h00) |=> access_flag;
    endproperty
    a_chk_bad_margin: assert property (p_chk_bad_margin)
        else $error("program check margin zero accepted");

    sequence s_mismatch;
        read_done && read_mismatch;
    endsequence
    property p_verify;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_mismatch |=> verify_flag;
    endproperty
    a_verify: assert property (p_verify)
        else $error("mismatch did not set verify failure");

    property p_launch_clears;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state == S_IDLE && launch) |=> !complete_flag [*2];
    endproperty
    a_launch_clears: assert property (p_launch_clears)
        else $error("complete flag not held low after launch");

    // The second program check read must use the matching margin-0 level.
    sequence s_first_check_read;
        read_done && is_chk && !second_pass;
    endsequence
    sequence s_zero_margin_read;
        arr_rd_o && ((chk_margin == margin_cmd_pkg::MARGIN_USER)
                     ? arr_level_o == margin_cmd_pkg::LVL_USER_0
                     : arr_level_o == margin_cmd_pkg::LVL_FACTORY_0);
    endsequence
    property p_second_pass;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_first_check_read |=> ##1 s_zero_margin_read;
    endproperty
    a_second_pass: assert property (p_second_pass)
        else $error("program check second read not at margin-0");
endmodule

//--- verif/flash_array_model.sv
// Behavioural flash array answering the sequencer's array reads.
// Assumes one-cycle read pulses and data taken within READ_LAT cycles.
`timescale 1ns/1ps
module flash_array_model #(
    parameter int READ_LAT = 2
) (
    input  wire logic        core_clk_i,  // System clock.
    input  wire logic        rd_i,        // Read request pulse.
    input  wire logic [23:0] addr_i,      // Longword byte address.
    input  wire logic [2:0]  level_i,     // Reference level.
    input  wire logic [23:0] flt_addr_i,  // Address that reads wrongly.
    input  wire logic [2:0]  flt_level_i, // Level at which it does so.
    output logic      [31:0] rdata_o      // Read data.
);
    logic [31:0] held = 32'h00000000;
    int          cnt  = 0;

    // The low megabyte is erased; above it each word holds an address
    // pattern with its most significant byte at the lowest address.
    function automatic logic [31:0] word(logic [23:0] a, logic [2:0] l);
        logic [31:0] w;
        w = (a[23:20] == 4'h0) ? 32'hffffffff
                               : {a[7:0], ~a[7:0], a[15:8], 8'h5a};
        if (a == flt_addr_i && l == flt_level_i)
            w = w ^ 32'h00010000;
        return w;
    endfunction

    // Data stand for READ_LAT + 1 cycles after a request, then change every
    // cycle so that a late sample never sees a stale match.
    always @(posedge core_clk_i) begin
        if (rd_i) begin
            held <= word(addr_i, level_i);
            cnt  <= READ_LAT;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end else begin
            held <= ~held;
        end
    end

    assign rdata_o = rd_i ? word(addr_i, level_i) : held;
endmodule

//--- verif/flash_margin_read_commands_tb_top.sv
// Self-checking bench for the margin-read command sequencer.
// Assumes the design package and the flash array model beside it.
`timescale 1ns/1ps
module flash_margin_read_commands_tb_top;
    typedef logic [7:0] prm_t [12];
    logic        core_clk_i  = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic [7:0]  reg_addr_i  = 8'h00;
    logic [31:0] reg_wdata_i = 32'h00000000;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic        cpu_rd_i    = 1'b0;
    logic [23:0] flt_addr    = 24'hffffff;
    logic [2:0]  flt_level   = 3'h7;
    logic        rd_d        = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [31:0] arr_rdata_i;
    logic [23:0] arr_addr_o;
    logic [2:0]  arr_level_o;
    logic        arr_rd_o;
    logic        busy_o;
    int          mismatches  = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    logic [31:0] rq[$];
    logic [26:0] aq[$];

    margin_read_sequencer #(.READ_LAT(2)) DUT (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cpu_rd_i(cpu_rd_i), .arr_rd_o(arr_rd_o),
        .arr_addr_o(arr_addr_o), .arr_level_o(arr_level_o),
        .arr_rdata_i(arr_rdata_i), .busy_o(busy_o));

    flash_array_model #(.READ_LAT(2)) flash (
        .core_clk_i(core_clk_i), .rd_i(arr_rd_o), .addr_i(arr_addr_o),
        .level_i(arr_level_o), .flt_addr_i(flt_addr),
        .flt_level_i(flt_level), .rdata_o(arr_rdata_i));

    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    task automatic complete_run();
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic bad(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // The expected value is noted before the strobe goes out.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
    endtask

    function automatic prm_t ones(logic [23:0] a, logic [15:0] n,
                                  logic [7:0] m);
        return '{margin_cmd_pkg::CMD_READ_ONES, a[23:16], a[15:8], a[7:0],
                 n[15:8], n[7:0], m, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    endfunction

    function automatic prm_t pc(logic [23:0] a, logic [7:0] m,
                                logic [31:0] w);
        return '{margin_cmd_pkg::CMD_PGM_CHECK, a[23:16], a[15:8], a[7:0],
                 m, 8'h00, 8'h00, 8'h00, w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    function automatic logic [31:0] pat(logic [23:0] a);
        return {a[7:0], ~a[7:0], a[15:8], 8'h5a};
    endfunction

    // Loads all parameter bytes, launches, waits and checks the status.
    task automatic run(input prm_t p, input logic [7:0] st);
        int n;
        for (int i = 0; i < 12; i++)
            wr(margin_cmd_pkg::PARAM_BASE_OFS + 8'(4 * i), {24'h0, p[i]});
        wr(margin_cmd_pkg::STATUS_OFS, 32'h00000080);
        n = 0;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        while (busy_o !== 1'b0 && n < 2000) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n == 2000) bad("busy stuck");
        rd(margin_cmd_pkg::STATUS_OFS, {24'h0, st});
        @(posedge core_clk_i);
        checks_done++;
        if (aq.size() != 0) bad("array reads missing");
        aq.delete();
    endtask

    always @(posedge core_clk_i) begin
        logic [31:0] e;
        cycles++;
        rd_d <= reg_rd_i;
        if (rd_d && rq.size() != 0) begin
            e = rq.pop_front();
            checks_done++;
            if (reg_rdata_o !== e) bad($sformatf("read %h not %h",
                                                 reg_rdata_o, e));
        end
        if (arr_rd_o === 1'b1) begin
            checks_done++;
            if (aq.size() == 0) bad("extra array read");
            else if ({arr_addr_o, arr_level_o} !== aq.pop_front())
                bad("array read address or level");
        end
        if (busy_o === 1'b0 &&
            arr_level_o !== margin_cmd_pkg::LVL_STANDARD)
            bad("margin level outside a command");
        if (cycles == 20000) begin
            bad("timeout");
            complete_run();
        end
    end

    initial begin
        logic [23:0] a;
        logic [2:0]  l1[3];
        prm_t        p;
        l1 = '{margin_cmd_pkg::LVL_NORMAL_1, margin_cmd_pkg::LVL_USER_1,
               margin_cmd_pkg::LVL_FACTORY_1};
        void'($urandom(32'h791271e9));
        repeat (4) @(posedge core_clk_i);
        rst_n_i  <= 1'b1;
        cpu_rd_i <= 1'b1;
        @(posedge core_clk_i);
        cpu_rd_i <= 1'b0;
        rd(margin_cmd_pkg::STATUS_OFS, 32'h00000080);
        rd(8'h08, 32'h00000000);
        for (int m = 0; m < 3; m++) begin
            a = 24'($urandom_range(0, 32'hfff0)) & 24'hfffffc;
            for (int k = 0; k < 3; k++)
                aq.push_back({a + 24'(4 * k), l1[m]});
            run(ones(a, 16'd3, 8'(m)), 8'h80);
        end
        flt_addr  <= a + 24'h4;
        flt_level <= margin_cmd_pkg::LVL_USER_1;
        aq.push_back({a, l1[1]});
        aq.push_back({a + 24'h4, l1[1]});
        run(ones(a, 16'd2, 8'h01), 8'h81);
        flt_addr  <= 24'hffffff;
        for (int e = 0; e < 9; e++) begin
            p = ones(24'h000100, 16'd1, 8'h00);
            case (e)
                0: p[0] = 8'h03;
                1: p[6] = 8'h03;
                2: p[3] = 8'h02;
                3: p[5] = 8'h00;
                4: p = ones(24'h01fffc, 16'd2, 8'h00);
                5: wr(margin_cmd_pkg::MODE_OFS, 32'h00000001);
                6: p = pc(24'h100000, 8'h00, 32'h0);
                7: p = pc(24'h100000, 8'h03, 32'h0);
                default: p = pc(24'h100001, 8'h01, 32'h0);
            endcase
            run(p, 8'ha0);
            wr(margin_cmd_pkg::MODE_OFS, 32'h00000000);
            wr(margin_cmd_pkg::STATUS_OFS, 32'h00000080);
            rd(margin_cmd_pkg::STATUS_OFS, 32'h000000a0);
            wr(margin_cmd_pkg::STATUS_OFS, 32'h00000020);
            rd(margin_cmd_pkg::STATUS_OFS, 32'h00000080);
        end
        for (int m = 1; m < 3; m++) begin
            a = 24'h100000 | (24'($urandom()) & 24'h0ffffc);
            aq.push_back({a, m == 1 ? margin_cmd_pkg::LVL_USER_1
                                    : margin_cmd_pkg::LVL_FACTORY_1});
            aq.push_back({a, m == 1 ? margin_cmd_pkg::LVL_USER_0
                                    : margin_cmd_pkg::LVL_FACTORY_0});
            run(pc(a, 8'(m), pat(a)), 8'h80);
        end
        flt_addr  <= a;
        flt_level <= margin_cmd_pkg::LVL_FACTORY_0;
        aq.push_back({a, margin_cmd_pkg::LVL_FACTORY_1});
        aq.push_back({a, margin_cmd_pkg::LVL_FACTORY_0});
        run(pc(a, 8'h02, pat(a)), 8'h81);
        flt_addr <= 24'hffffff;
        for (int k = 0; k < 20; k++)
            aq.push_back({24'h000200 + 24'(4 * k), l1[0]});
        fork
            run(ones(24'h000200, 16'd20, 8'h00), 8'hc0);
            begin
                repeat (40) @(posedge core_clk_i);
                cpu_rd_i <= 1'b1;
                @(posedge core_clk_i);
                cpu_rd_i <= 1'b0;
            end
        join
        wr(margin_cmd_pkg::STATUS_OFS, 32'h00000040);
        rd(margin_cmd_pkg::STATUS_OFS, 32'h00000080);
        repeat (3) @(posedge core_clk_i);
        complete_run();
    end
endmodule
